// file: remote_regs_pkg.sv
package remote_regs_pkg;
   localparam int          ADDR_W          = 3;
   localparam int          DATA_W          = 16;
   localparam logic [2:0]  SENSOR_CFG_ADDR = 3'h1;
   localparam logic [2:0]  BRIGHT_CMD_ADDR = 3'h2;
   localparam logic [2:0]  AUTO_OVR_ADDR   = 3'h3;
   localparam logic [2:0]  OVR_VAL1_ADDR   = 3'h4;
   localparam logic [2:0]  OVR_VAL2_ADDR   = 3'h5;
   localparam int          CONTRAST_LSB    = 8;
   localparam int          SUBPIX_BIT      = 14;
   localparam int          STATIC_BIT      = 15;
   localparam int          RLE_BIT         = 15;
   localparam int          RBL_BIT         = 14;
   localparam int          MAX_LSB         = 7;
   localparam int          S1A_BIT         = 15;
   localparam int          SENSOR1_BRIGHT_OVERRIDE_BIT        = 14;
   localparam int          S2A_BIT         = 7;
   localparam int          SENSOR2_BRIGHT_OVERRIDE_BIT        = 6;
   localparam logic [5:0]  CONTRAST_RST    = 6'h20;
   localparam logic [6:0]  LIMIT_MAX_NET   = 7'h7D;
   localparam logic [6:0]  NORM_MIN        = 7'h04;
   localparam logic [6:0]  NORM_MAX        = 7'h64;
   localparam logic [6:0]  OVR_MAX         = 7'h40;
   localparam logic [6:0]  BRIGHT_RST      = 7'h32;
endpackage

// file: bright_if.sv
`timescale 1ns/1ps
interface bright_if;
   logic       limit_en;
   logic [6:0] lim_lo;
   logic [6:0] lim_hi;
   logic       auto_en;
   logic       load;
   logic [6:0] load_val;
   logic [6:0] auto_val;
   logic [6:0] level;
   modport ctl (output limit_en, lim_lo, lim_hi, auto_en, load, load_val, auto_val,
                input level);
   modport chan (input limit_en, lim_lo, lim_hi, auto_en, load, load_val, auto_val,
                 output level);
endinterface

// file: bright_chan.sv
`timescale 1ns/1ps
module bright_chan (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   bright_if.chan   bus
);
   typedef struct packed {
      logic [6:0] level;
   } chan_s;
   chan_s st_q;
   chan_s st_d;
   logic [6:0] lo;
   logic [6:0] hi;
   logic [6:0] want;

   always_comb begin
      st_d = st_q;
      lo   = bus.limit_en ? bus.lim_lo : remote_regs_pkg::NORM_MIN;
      hi   = bus.limit_en ? bus.lim_hi : remote_regs_pkg::NORM_MAX;
      want = st_q.level;
      // A written value seeds the level; with auto on it is only a starting point.
      if (bus.load) begin // RQ17
         want = bus.load_val;
      end else if (bus.auto_en) begin // RQ13
         want = bus.auto_val;
      end
      // Clamping applies to manual, override and automatic changes alike.
      if (want < lo) begin // RQ9
         want = lo;
      end
      if (want > hi) begin // RQ9
         want = hi;
      end
      // Frozen level still follows limits, otherwise it is held.
      st_d.level = want; // RQ14
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q.level <= remote_regs_pkg::BRIGHT_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.level = st_q.level;

   a_level_limit : assert property (@(posedge clock) disable iff (!rst_n)
      $past(bus.limit_en) |-> (st_q.level >= $past(bus.lim_lo)
                               && st_q.level <= $past(bus.lim_hi))) // RQ9
      else $error("brightness outside remote limits");
   a_frozen_hold : assert property (@(posedge clock) disable iff (!rst_n)
      (!bus.auto_en && !bus.load && $stable(bus.lim_lo) && $stable(bus.lim_hi)
       && $stable(bus.limit_en) && st_q.level >= bus.lim_lo
       && st_q.level <= bus.lim_hi && bus.limit_en) |=> $stable(st_q.level)) // RQ14
      else $error("frozen brightness changed");
endmodule

// file: remote_sensor_brightness_regs.sv
`timescale 1ns/1ps
// Functional notes
// (RQ1) Six-bit minimum contrast in config bits 13..8, default 32.
// (RQ2) Config bit 14 enables fourfold sub-pixel edge resolution.
// (RQ3) Config bit 15 one selects static thresholding, zero dynamic.
// (RQ4) Word 2 bit 15 gates every remote brightness setting.
// (RQ5) Word 2 bit 14 enables remote limits; otherwise range 4 to 100.
// (RQ6) Word 2 holds max limit in bits 13..7, min in 6..0.
// (RQ7) One limit pair serves both sensors; controller keeps max not below min.
// (RQ8) Network limits accepted 0 to 125; local limits 0 to 100.
// (RQ9) Limits clamp brightness in manual and automatic adjustment.
// (RQ10) Last remote limits persist after the link is lost.
// (RQ11) Local sub-pixel setting reverts on power cycle if remote bit clear.
// (RQ12) Local static setting reverts on power cycle if remote bit clear.
// (RQ13) Word 3 bits 15 and 7 enable auto brightness, under remote control.
// (RQ14) Disabling auto brightness holds the last brightness value.
// (RQ15) Word 3 bits 14 and 6 enable brightness override per sensor.
// (RQ16) Override values range 0 to 64, taken only while override is set.
// (RQ17) With auto on, an override value only seeds the algorithm.
// (RQ18) A limit pair with max below min is ignored; old limits kept.
module remote_sensor_brightness_regs (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Remote word write/read port
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [2:0]  addr,
   input  wire logic [15:0] wr_data,
   output logic [15:0]      rd_data,
   output logic             rd_valid,
   // Local operator settings
   input  wire logic        local_subpix_set,
   input  wire logic        local_static_set,
   input  wire logic        link_up,
   // Automatic algorithm proposals
   input  wire logic [6:0]  auto_val1,
   input  wire logic [6:0]  auto_val2,
   // Edge sensor configuration
   output logic [5:0]       min_contrast,
   output logic             subpixel_en,
   output logic             static_thresh,
   // Brightness results
   output logic [6:0]       bright1,
   output logic [6:0]       bright2,
   output logic             limit_active,
   output logic [6:0]       limit_lo,
   output logic [6:0]       limit_hi
);
   typedef struct packed {
      logic [5:0]  contrast;
      logic        subpix;
      logic        stat;
      logic        rle;
      logic        remote_limit_enable;
      logic [6:0]  lo;
      logic [6:0]  hi;
      logic [15:0] ovr_word;
      logic [6:0]  ovr1;
      logic [6:0]  ovr2;
      logic        ld1;
      logic        ld2;
      logic [15:0] rdat;
      logic        rval;
      logic [2:0]  sub_sync;
      logic [2:0]  sta_sync;
      logic [2:0]  lnk_sync;
      logic        lnk;
   } regs_s;
   regs_s st_q;
   regs_s st_d;

   bright_if ch1 ();
   bright_if ch2 ();

   logic [6:0] wr_lo;
   logic [6:0] wr_hi;
   logic       sub_chg;
   logic       sta_chg;

   assign wr_lo   = wr_data[6:0];
   assign wr_hi   = wr_data[remote_regs_pkg::MAX_LSB +: 7];
   // Two later stages must agree before a pin change counts.
   assign sub_chg = (st_q.sub_sync[1] == st_q.sub_sync[2]);
   assign sta_chg = (st_q.sta_sync[1] == st_q.sta_sync[2]);

   always_comb begin
      st_d          = st_q;
      st_d.ld1      = 1'b0;
      st_d.ld2      = 1'b0;
      st_d.rval     = 1'b0;
      st_d.sub_sync = {st_q.sub_sync[1:0], local_subpix_set};
      st_d.sta_sync = {st_q.sta_sync[1:0], local_static_set};
      st_d.lnk_sync = {st_q.lnk_sync[1:0], link_up};
      if (st_q.lnk_sync[1] == st_q.lnk_sync[2]) begin
         st_d.lnk = st_q.lnk_sync[2];
      end
      // Local settings only live in volatile state; reset restores remote defaults.
      if (sub_chg && st_q.sub_sync[2] && !st_q.subpix) begin // RQ11
         st_d.subpix = 1'b1;
      end
      if (sta_chg && st_q.sta_sync[2] && !st_q.stat) begin // RQ12
         st_d.stat = 1'b1;
      end
      if (wr_en) begin
         case (addr)
            remote_regs_pkg::SENSOR_CFG_ADDR: begin
               st_d.contrast = wr_data[remote_regs_pkg::CONTRAST_LSB +: 6]; // RQ1
               st_d.subpix   = wr_data[remote_regs_pkg::SUBPIX_BIT]; // RQ2
               st_d.stat     = wr_data[remote_regs_pkg::STATIC_BIT]; // RQ3
            end
            remote_regs_pkg::BRIGHT_CMD_ADDR: begin
               st_d.rle = wr_data[remote_regs_pkg::RLE_BIT];
               st_d.remote_limit_enable = wr_data[remote_regs_pkg::RBL_BIT];
               // Bad or out-of-range pairs are dropped whole.
               if (wr_hi >= wr_lo && wr_hi <= remote_regs_pkg::LIMIT_MAX_NET) begin // RQ18 RQ8
                  st_d.lo = wr_lo; // RQ6
                  st_d.hi = wr_hi; // RQ6
               end
            end
            remote_regs_pkg::AUTO_OVR_ADDR: begin
               st_d.ovr_word = wr_data;
            end
            remote_regs_pkg::OVR_VAL1_ADDR: begin
               // Full scale 64 needs a seventh bit, so the value is taken from bits 6..0.
               if (st_q.ovr_word[remote_regs_pkg::SENSOR1_BRIGHT_OVERRIDE_BIT] && st_q.rle
                   && wr_data[6:0] <= remote_regs_pkg::OVR_MAX) begin // RQ16 RQ15
                  st_d.ovr1 = wr_data[6:0];
                  st_d.ld1  = 1'b1;
               end
            end
            remote_regs_pkg::OVR_VAL2_ADDR: begin
               if (st_q.ovr_word[remote_regs_pkg::SENSOR2_BRIGHT_OVERRIDE_BIT] && st_q.rle
                   && wr_data[6:0] <= remote_regs_pkg::OVR_MAX) begin // RQ16 RQ15
                  st_d.ovr2 = wr_data[6:0];
                  st_d.ld2  = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      if (rd_en) begin
         st_d.rval = 1'b1;
         case (addr)
            remote_regs_pkg::SENSOR_CFG_ADDR:
               st_d.rdat = {st_q.stat, st_q.subpix, st_q.contrast, 8'h00};
            remote_regs_pkg::BRIGHT_CMD_ADDR:
               st_d.rdat = {st_q.rle, st_q.remote_limit_enable, st_q.hi, st_q.lo};
            remote_regs_pkg::AUTO_OVR_ADDR:
               st_d.rdat = st_q.ovr_word;
            remote_regs_pkg::OVR_VAL1_ADDR:
               st_d.rdat = {9'h000, ch1.level};
            remote_regs_pkg::OVR_VAL2_ADDR:
               st_d.rdat = {9'h000, ch2.level};
            default:
               st_d.rdat = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q          <= '0;
         st_q.contrast <= remote_regs_pkg::CONTRAST_RST;
         st_q.lo       <= remote_regs_pkg::NORM_MIN;
         st_q.hi       <= remote_regs_pkg::NORM_MAX;
      end else begin
         st_q <= st_d;
      end
   end

   // Remote gating; the limit pair is shared by both sensors and outlives the link.
   assign ch1.limit_en = st_q.rle && st_q.remote_limit_enable; // RQ4 RQ5 RQ7 RQ10
   assign ch2.limit_en = st_q.rle && st_q.remote_limit_enable; // RQ4 RQ5 RQ7
   assign ch1.lim_lo   = st_q.lo;
   assign ch1.lim_hi   = st_q.hi;
   assign ch2.lim_lo   = st_q.lo;
   assign ch2.lim_hi   = st_q.hi;
   // Without remote light control the channels keep their automatic behaviour.
   assign ch1.auto_en  = !st_q.rle || st_q.ovr_word[remote_regs_pkg::S1A_BIT]; // RQ13 RQ4
   assign ch2.auto_en  = !st_q.rle || st_q.ovr_word[remote_regs_pkg::S2A_BIT]; // RQ13 RQ4
   assign ch1.load     = st_q.ld1;
   assign ch2.load     = st_q.ld2;
   assign ch1.load_val = st_q.ovr1;
   assign ch2.load_val = st_q.ovr2;
   assign ch1.auto_val = auto_val1;
   assign ch2.auto_val = auto_val2;

   bright_chan u_chan1 (
      .clock (clock),
      .rst_n (rst_n),
      .bus   (ch1)
   );
   bright_chan u_chan2 (
      .clock (clock),
      .rst_n (rst_n),
      .bus   (ch2)
   );

   logic [6:0] b1_q;
   logic [6:0] b2_q;
   logic       lim_act_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         b1_q      <= remote_regs_pkg::BRIGHT_RST;
         b2_q      <= remote_regs_pkg::BRIGHT_RST;
         lim_act_q <= 1'b0;
      end else begin
         b1_q      <= ch1.level;
         b2_q      <= ch2.level;
         lim_act_q <= st_q.rle && st_q.remote_limit_enable; // RQ4 RQ5
      end
   end

   assign min_contrast  = st_q.contrast;
   assign subpixel_en   = st_q.subpix;
   assign static_thresh = st_q.stat;
   assign rd_data       = st_q.rdat;
   assign rd_valid      = st_q.rval;
   assign bright1       = b1_q;
   assign bright2       = b2_q;
   assign limit_active  = lim_act_q;
   assign limit_lo      = st_q.lo;
   assign limit_hi      = st_q.hi;

   a_contrast_wr : assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == remote_regs_pkg::SENSOR_CFG_ADDR) |=>
      (min_contrast == $past(wr_data[13:8]) && subpixel_en == $past(wr_data[14]))) // RQ1
      else $error("config write not stored");
   a_static_wr : assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == remote_regs_pkg::SENSOR_CFG_ADDR) |=>
      static_thresh == $past(wr_data[15])) // RQ3
      else $error("threshold select not stored");
   a_bad_pair : assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == remote_regs_pkg::BRIGHT_CMD_ADDR && wr_hi < wr_lo) |=>
      $stable(limit_lo) && $stable(limit_hi)) // RQ18
      else $error("invalid limit pair accepted");
   a_good_pair : assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == remote_regs_pkg::BRIGHT_CMD_ADDR && wr_hi >= wr_lo
       && wr_hi <= 7'h7D) |=> (limit_lo == $past(wr_lo) && limit_hi == $past(wr_hi))) // RQ6
      else $error("valid limit pair dropped");
   a_limit_gate : assert property (@(posedge clock) disable iff (!rst_n)
      limit_active == $past(st_q.rle && st_q.remote_limit_enable)) // RQ4
      else $error("limit gate wrong");
   a_ovr_gate : assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == remote_regs_pkg::OVR_VAL1_ADDR
       && !st_q.ovr_word[remote_regs_pkg::SENSOR1_BRIGHT_OVERRIDE_BIT]) |=> !st_q.ld1) // RQ15
      else $error("override taken while disabled");
   a_ovr_range : assert property (@(posedge clock) disable iff (!rst_n)
      st_q.ovr1 <= 7'h40 && st_q.ovr2 <= 7'h40) // RQ16
      else $error("override value out of range");
   a_net_range : assert property (@(posedge clock) disable iff (!rst_n)
      limit_hi <= 7'h7D && limit_lo <= limit_hi) // RQ8
      else $error("limit beyond network range");
endmodule

// file: plc_model.sv
`timescale 1ns/1ps
module plc_model (
   // Clock
   input  wire logic   clock,
   // Word requests toward the device
   output logic        wr_en,
   output logic        rd_en,
   output logic [2:0]  addr,
   output logic [15:0] wr_data
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 3'h0;
      wr_data = 16'h5A5A;
   end

   // A careful controller never sends an inverted limit pair or an oversized override.
   // The bad flag lifts that guard only where a scenario wants the device to refuse.
   task automatic write_word(input logic [2:0] a, input logic [15:0] d, input bit bad);
      if (!bad && a == 3'h2 && d[13:7] < d[6:0]) return;
      if (!bad && a[2] && d > 16'h0040) return;
      @(posedge clock);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      addr <= ~a;
      wr_data <= ~d;
   endtask

   task automatic read_word(input logic [2:0] a);
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      addr <= ~a;
   endtask
endmodule

// file: remote_sensor_brightness_regs_tb_top.sv
`timescale 1ns/1ps
module remote_sensor_brightness_regs_tb_top;
   logic        clock, rst_n, wr_en, rd_en, rd_valid;
   logic [2:0]  addr;
   logic [15:0] wr_data, rd_data;
   logic        l_sub, l_stat, link_up, limit_active, subpixel_en, static_thresh;
   logic [6:0]  auto_val1, auto_val2, bright1, bright2, limit_lo, limit_hi;
   logic [5:0]  min_contrast, c;
   logic [31:0] rng_q = 32'h24ED;
   logic [15:0] exp_q[$];
   int          num_errors = 0;
   int          tests_run = 0;
   int          cyc_q = 0;

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   plc_model i_plc (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
                    .wr_data(wr_data));
   remote_sensor_brightness_regs i_dut (
      .clock(clock), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
      .local_subpix_set(l_sub), .local_static_set(l_stat), .link_up(link_up),
      .auto_val1(auto_val1), .auto_val2(auto_val2), .min_contrast(min_contrast),
      .subpixel_en(subpixel_en), .static_thresh(static_thresh), .bright1(bright1),
      .bright2(bright2), .limit_active(limit_active), .limit_lo(limit_lo),
      .limit_hi(limit_hi));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [6:0] clamp(input logic [6:0] v, lo, hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction

   task automatic chk_out(input string nm, input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rd(input logic [15:0] e);
      chk_out("rd_data", rd_data, e);
   endtask

   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      i_plc.read_word(a);
   endtask

   task automatic settle;
      repeat (4) @(posedge clock);
      #1;
   endtask

   task automatic drive_auto(input logic [6:0] v1, input logic [6:0] v2);
      @(posedge clock);
      auto_val1 <= v1;
      auto_val2 <= v2;
      settle();
   endtask

   task automatic do_reset;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      settle();
   endtask

   task automatic lim(input logic [6:0] lo, input logic [6:0] hi);
      chk_out("limit_lo", 16'(limit_lo), 16'(lo));
      chk_out("limit_hi", 16'(limit_hi), 16'(hi));
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // A read answer with nothing expected is forced to mismatch by comparing with its inverse.
   always @(posedge clock) begin
      if (rd_valid === 1'b1) chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data);
   end

   always @(posedge clock) begin
      cyc_q++;
      if (cyc_q == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      {rst_n, l_sub, l_stat, link_up} = 4'b0001;
      auto_val1 = 7'h00;
      auto_val2 = 7'h00;
      do_reset();
      chk_out("min_contrast", 16'(min_contrast), 16'h0020);
      chk_out("flags", 16'({subpixel_en, static_thresh, limit_active}), 16'h0000);
      lim(7'h04, 7'h64);
      rd(3'h2, {2'b00, 7'h64, 7'h04});
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         rng_q = xs(rng_q);
         c = (i == 0) ? 6'h00 : (i == 3) ? 6'h3F : rng_q[5:0];
         i_plc.write_word(3'h1, {i[1], i[0], c, 8'h00}, 1'b0);
         settle();
         chk_out("min_contrast", 16'(min_contrast), 16'(c));
         chk_out("subpixel_en", 16'(subpixel_en), 16'(i[0]));
         chk_out("static_thresh", 16'(static_thresh), 16'(i[1]));
      end
      i_plc.write_word(3'h1, 16'h2000, 1'b0);
      @(posedge clock);
      {l_sub, l_stat} <= 2'b11;
      repeat (2) settle();
      chk_out("local_set", 16'({subpixel_en, static_thresh}), 16'h0003);
      @(posedge clock);
      {l_sub, l_stat} <= 2'b00;
      repeat (2) settle();
      do_reset();
      chk_out("power_cycle", 16'({subpixel_en, static_thresh}), 16'h0000);
      $display("test config done");
      i_plc.write_word(3'h3, 16'h8080, 1'b0);
      i_plc.write_word(3'h2, {2'b11, 7'h7D, 7'h05}, 1'b0);
      settle();
      chk_out("limit_active", 16'(limit_active), 16'h0001);
      lim(7'h05, 7'h7D);
      rd(3'h2, {2'b11, 7'h7D, 7'h05});
      for (int i = 0; i < 6; i++) begin
         rng_q = xs(rng_q);
         if (i == 0) rng_q[14:0] = 15'h007F;
         drive_auto(rng_q[6:0], rng_q[14:8]);
         chk_out("bright1", 16'(bright1), 16'(clamp(rng_q[6:0], 7'h05, 7'h7D)));
         chk_out("bright2", 16'(bright2), 16'(clamp(rng_q[14:8], 7'h05, 7'h7D)));
      end
      i_plc.write_word(3'h2, {2'b11, 7'h0A, 7'h14}, 1'b1);
      i_plc.write_word(3'h2, {2'b11, 7'h7E, 7'h05}, 1'b1);
      settle();
      lim(7'h05, 7'h7D);
      @(posedge clock);
      link_up <= 1'b0;
      settle();
      lim(7'h05, 7'h7D);
      @(posedge clock);
      link_up <= 1'b1;
      i_plc.write_word(3'h2, {2'b11, 7'h30, 7'h30}, 1'b0);
      drive_auto(7'h7F, 7'h00);
      chk_out("bright_eq", 16'({bright1, bright2}), 16'({7'h30, 7'h30}));
      $display("test limits done");
      i_plc.write_word(3'h2, {2'b10, 7'h7D, 7'h05}, 1'b0);
      settle();
      chk_out("limit_active", 16'(limit_active), 16'h0000);
      chk_out("bright_norm", 16'({bright1, bright2}), 16'({7'h64, 7'h04}));
      drive_auto(7'h3C, 7'h00);
      i_plc.write_word(3'h3, 16'h0000, 1'b0);
      drive_auto(7'h5A, 7'h00);
      chk_out("bright1", 16'(bright1), 16'h003C);
      i_plc.write_word(3'h2, 16'h0000, 1'b0);
      settle();
      chk_out("bright1", 16'(bright1), 16'h005A);
      $display("test auto done");
      i_plc.write_word(3'h2, {2'b10, 7'h7D, 7'h05}, 1'b0);
      i_plc.write_word(3'h3, 16'h4000, 1'b0);
      i_plc.write_word(3'h4, 16'h0040, 1'b0);
      i_plc.write_word(3'h4, 16'h0041, 1'b1);
      i_plc.write_word(3'h5, 16'h001E, 1'b0);
      settle();
      chk_out("bright_ovr", 16'({bright1, bright2}), 16'({7'h40, 7'h04}));
      rd(3'h4, 16'h0040);
      rd(3'h0, 16'h0000);
      rd(3'h6, 16'h0000);
      rd(3'h7, 16'h0000);
      settle();
      chk_out("reads_pending", 16'(exp_q.size()), 16'h0000);
      $display("test override done");
      report_and_stop();
   end
endmodule
